// *** rtl/dac_ctrl_pkg.sv ***
// shared types and constants for the converter load, busy and reset control
// assumes a single 20 MHz system clock and pins already synchronous to it
package dac_ctrl_pkg;

	localparam int unsigned CODE_W = 18;

	// clock and timing
	localparam int unsigned CLK_PERIOD_NS   = 50;
	localparam int unsigned SW_RESET_NS     = 200;
	localparam int unsigned SW_RESET_CYCLES =
		(SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0]  SW_RESET_CNT    = 3'(SW_RESET_CYCLES);
	localparam logic [4:0]  MUL_STEPS       = 5'h12;

	// reset values
	localparam logic [CODE_W-1:0] GAIN_RESET   = 18'h3_FFFF;
	localparam logic [CODE_W-1:0] OFFSET_RESET = 18'h0_0000;
	localparam int unsigned       MSB          = CODE_W - 1;
	localparam logic [CODE_W-1:0] CODE_MAX     = 18'h3_FFFF;

	// which input register a decoded serial frame writes
	typedef enum logic [1:0] {
		TGT_DATA   = 2'b00,
		TGT_OFFSET = 2'b01,
		TGT_GAIN   = 2'b10,
		TGT_NONE   = 2'b11
	} wr_target_t;

	typedef struct packed {
		logic              valid;
		wr_target_t        target;
		logic [CODE_W-1:0] value;
	} frame_write_t;

	// snapshot handed to the update engine
	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic [CODE_W-1:0] gain;
		logic [CODE_W-1:0] offset;
	} calc_req_t;

	typedef enum logic [1:0] {
		CALC_IDLE = 2'b00,
		CALC_MUL  = 2'b01,
		CALC_ADD  = 2'b11
	} calc_state_t;

endpackage

// *** rtl/dac_update_engine.sv ***
// sequential gain and offset calculation of the converter register value
// assumes start only when idle; abort drops a calculation in progress
module dac_update_engine (
	// clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  reset_i,
	// control
	input  wire logic                  abort_i,
	input  wire logic                  start_i,
	input  wire dac_ctrl_pkg::calc_req_t req_i,
	// status and result
	output logic                       busy_o,
	output logic                       done_o,
	output logic [17:0]                result_o
);

	dac_ctrl_pkg::calc_state_t state_q;
	logic [35:0] acc_q;
	logic [35:0] mcand_q;
	logic [17:0] mplier_q;
	logic [17:0] offset_q;
	logic [4:0]  step_q;
	logic [19:0] sum;

	// product keeps its upper half, so full gain is just under unity
	assign sum    = {2'b00, acc_q[35:18]} + {{2{offset_q[17]}}, offset_q};
	assign busy_o = (state_q != dac_ctrl_pkg::CALC_IDLE);

	always_ff @(posedge sys_clk_i) begin
		if (reset_i || abort_i) begin
			state_q <= dac_ctrl_pkg::CALC_IDLE;
		end else begin
			unique case (state_q)
				dac_ctrl_pkg::CALC_IDLE: if (start_i) state_q <= dac_ctrl_pkg::CALC_MUL;
				dac_ctrl_pkg::CALC_MUL:  if (step_q == 5'h01) state_q <= dac_ctrl_pkg::CALC_ADD;
				dac_ctrl_pkg::CALC_ADD:  state_q <= dac_ctrl_pkg::CALC_IDLE;
				default:                 state_q <= dac_ctrl_pkg::CALC_IDLE;
			endcase
		end
	end

	// one multiplier bit per cycle: slow, but the busy window covers it
	always_ff @(posedge sys_clk_i) begin
		if (start_i && !busy_o) begin
			acc_q    <= 36'h0_0000_0000;
			mcand_q  <= {18'h0_0000, req_i.code};
			mplier_q <= req_i.gain;
			offset_q <= req_i.offset;
			step_q   <= dac_ctrl_pkg::MUL_STEPS;
		end else if (state_q == dac_ctrl_pkg::CALC_MUL) begin
			acc_q    <= mplier_q[0] ? acc_q + mcand_q : acc_q;
			mcand_q  <= {mcand_q[34:0], 1'b0};
			mplier_q <= {1'b0, mplier_q[17:1]};
			step_q   <= step_q - 5'h01;
		end
	end

	// offset is signed; the result saturates at both ends of the scale
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			done_o   <= 1'b0;
			result_o <= 18'h0_0000;
		end else begin
			done_o <= (state_q == dac_ctrl_pkg::CALC_ADD) && !abort_i;
			if (state_q == dac_ctrl_pkg::CALC_ADD) begin
				if (sum[19])
					result_o <= 18'h0_0000;
				else if (sum[18])
					result_o <= dac_ctrl_pkg::CODE_MAX;
				else
					result_o <= sum[17:0];
			end
		end
	end

endmodule

// *** rtl/dac_load_busy_reset_control.sv ***
// reset, load strobe, busy line and ready control around the converter register
// assumes the serial decoder supplies written words, frame-done and chip select,
// all synchronous to sys_clk_i; the busy line is open drain with a pull-up

module dac_load_busy_reset_control (
	// clock and reset
	input  wire logic                        sys_clk_i,
	input  wire logic                        reset_i,
	// reset and configuration pins
	input  wire logic                        hw_reset_n_i,
	input  wire logic                        sw_reset_i,
	input  wire logic                        reset_level_select_i,
	input  wire logic                        input_format_select_i,
	input  wire logic                        power_down_in_i,
	// serial decoder side
	input  wire logic                        cs_n_i,
	input  wire dac_ctrl_pkg::frame_write_t  frame_write_i,
	input  wire logic                        frame_done_i,
	// load strobe and busy line
	input  wire logic                        load_strobe_n_i,
	input  wire logic                        busy_n_i,
	output logic                             busy_n_o,
	output logic                             busy_n_oe_o,
	// ready and converter
	output logic                             ready_n_o,
	output logic [17:0]                      dac_code_o,
	output logic                             dac_update_o,
	output logic                             power_down_o
);

	logic        in_reset;
	logic        any_reset;
	logic        sw_active;
	logic [2:0]  sw_cnt_q;
	logic [17:0] data_q;
	logic [17:0] gain_q;
	logic [17:0] offset_q;
	logic [17:0] data_reset;
	logic [17:0] code_reset;
	logic [17:0] data_conv;
	logic        load_prev_q;
	logic        load_fall;
	logic        pending_q;
	logic        line_busy;
	logic        int_busy;
	logic        start;
	logic        cs_prev_q;
	logic        cs_rise;
	logic        eng_busy;
	logic        eng_done;
	logic [17:0] eng_result;
	dac_ctrl_pkg::calc_req_t calc_req;

	// hardware reset and power-on share one path; load activity is masked in both
	assign in_reset  = reset_i || !hw_reset_n_i;
	assign sw_active = (sw_cnt_q != 3'h0);
	assign any_reset = in_reset || sw_reset_i || sw_active;

	// raw default sits in the host format so both pins steer it
	assign data_reset = {reset_level_select_i ^ input_format_select_i, 17'h0_0000};
	assign code_reset = {reset_level_select_i, 17'h0_0000};
	// two's complement becomes offset binary by flipping the sign bit
	assign data_conv  = data_q ^ {input_format_select_i, 17'h0_0000};

	// software reset keeps busy low for a fixed window
	always_ff @(posedge sys_clk_i) begin
		if (in_reset)
			sw_cnt_q <= 3'h0;
		else if (sw_reset_i)
			sw_cnt_q <= dac_ctrl_pkg::SW_RESET_CNT;
		else if (sw_active)
			sw_cnt_q <= sw_cnt_q - 3'h1;
	end

	// input registers: writes land whatever the busy or power-down state
	always_ff @(posedge sys_clk_i) begin
		if (any_reset) begin
			data_q   <= data_reset;
			gain_q   <= dac_ctrl_pkg::GAIN_RESET;
			offset_q <= dac_ctrl_pkg::OFFSET_RESET;
		end else if (frame_write_i.valid) begin
			unique case (frame_write_i.target)
				dac_ctrl_pkg::TGT_DATA:   data_q   <= frame_write_i.value;
				dac_ctrl_pkg::TGT_OFFSET: offset_q <= frame_write_i.value;
				dac_ctrl_pkg::TGT_GAIN:   gain_q   <= frame_write_i.value;
				dac_ctrl_pkg::TGT_NONE:   ;
			endcase
		end
	end

	// starting low after reset release is not treated as a falling edge
	always_ff @(posedge sys_clk_i) begin
		if (reset_i)
			load_prev_q <= 1'b0;
		else
			load_prev_q <= load_strobe_n_i;
	end

	assign load_fall = load_prev_q && !load_strobe_n_i && !in_reset;
	assign int_busy  = any_reset || eng_busy;
	// the line is read as well, so an outside party holding it low defers us
	assign line_busy = !busy_n_i || int_busy;
	assign start     = !line_busy && (load_fall || pending_q);

	always_ff @(posedge sys_clk_i) begin
		if (any_reset)
			pending_q <= 1'b0;
		else if (start)
			pending_q <= 1'b0;
		else if (load_fall && line_busy)
			pending_q <= 1'b1;
	end

	assign calc_req = '{code: data_conv, gain: gain_q, offset: offset_q};

	dac_update_engine u_engine (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.abort_i   (any_reset),
		.start_i   (start),
		.req_i     (calc_req),
		.busy_o    (eng_busy),
		.done_o    (eng_done),
		.result_o  (eng_result)
	);

	// converter register: reset level until a load has been carried out
	// limitation: a hold applied from outside after a calculation has started
	// does not delay its result; only loads that have not yet started are deferred
	always_ff @(posedge sys_clk_i) begin
		if (any_reset) begin
			dac_code_o   <= code_reset;
			dac_update_o <= 1'b0;
		end else begin
			dac_update_o <= eng_done;
			if (eng_done)
				dac_code_o <= eng_result;
		end
	end

	// the pin level is always low; only the enable moves
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			busy_n_o    <= 1'b0;
			busy_n_oe_o <= 1'b1;
		end else begin
			busy_n_o    <= 1'b0;
			busy_n_oe_o <= int_busy || start;
		end
	end

	assign cs_rise = !cs_prev_q && cs_n_i;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i)
			cs_prev_q <= 1'b1;
		else
			cs_prev_q <= cs_n_i;
	end

	// a frame completing in the chip-select edge cycle still shows ready
	always_ff @(posedge sys_clk_i) begin
		if (reset_i)
			ready_n_o <= 1'b1;
		else if (frame_done_i)
			ready_n_o <= 1'b0;
		else if (cs_rise)
			ready_n_o <= 1'b1;
	end

	// power-down only reaches the analog side; nothing here is frozen by it
	always_ff @(posedge sys_clk_i) begin
		if (reset_i)
			power_down_o <= 1'b0;
		else
			power_down_o <= power_down_in_i;
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	// a strobe on the release cycle is a legal load, so it must stay high there
	sequence rst_release;
		!hw_reset_n_i ##1 (hw_reset_n_i && load_strobe_n_i);
	endsequence

	sequence calc_run;
		start ##1 (eng_busy && !any_reset)[*8];
	endsequence

	sequence sw_window;
		busy_n_oe_o[*5];
	endsequence

	chk_reset_defaults: assert property (
		!hw_reset_n_i |=> data_q == {$past(reset_level_select_i ^ input_format_select_i),
			17'h0_0000} && gain_q == dac_ctrl_pkg::GAIN_RESET
	) else $error("input registers not at default during hardware reset");

	chk_hold_after_rst: assert property (
		rst_release ##1 load_strobe_n_i[*3] |-> !dac_update_o && !eng_busy
	) else $error("converter changed after reset without a load strobe");

	chk_reset_level: assert property (
		any_reset |=> dac_code_o == {$past(reset_level_select_i), 17'h0_0000}
	) else $error("converter not at selected reset level");

	chk_ready_low: assert property (
		frame_done_i |=> !ready_n_o
	) else $error("ready not asserted after frame done");

	chk_ready_release: assert property (
		!cs_n_i ##1 (cs_n_i && !frame_done_i) |=> ready_n_o
	) else $error("ready not released on chip select rise");

	chk_busy_calc: assert property (
		eng_busy |=> busy_n_oe_o && !busy_n_o
	) else $error("busy line not driven during calculation");

	chk_write_busy: assert property (
		frame_write_i.valid && frame_write_i.target == dac_ctrl_pkg::TGT_DATA
			&& eng_busy && !any_reset |=> data_q == $past(frame_write_i.value)
	) else $error("data write lost while busy");

	chk_hold_busy: assert property (
		!busy_n_i && !eng_done && !any_reset |=> $stable(dac_code_o)
	) else $error("converter register changed while busy low");

	// own calculation excluded: the engine is then still busy when the strobe is stored
	chk_ext_defer: assert property (
		load_fall && !busy_n_i && !eng_busy && !any_reset |=> pending_q && !eng_busy
	) else $error("load not deferred by external busy");

	chk_reset_busy: assert property (
		any_reset |=> busy_n_oe_o && !busy_n_o
	) else $error("busy not driven low during reset");

	chk_load_update: assert property (
		calc_run |-> ##[1:14] dac_update_o
	) else $error("load strobe did not update the converter");

	chk_ignore_reset: assert property (
		!hw_reset_n_i |=> !pending_q && !eng_busy && !dac_update_o
	) else $error("load strobe acted during hardware reset");

	chk_pd_write: assert property (
		power_down_in_i && frame_write_i.valid && !any_reset
			&& frame_write_i.target == dac_ctrl_pkg::TGT_GAIN
			|=> gain_q == $past(frame_write_i.value)
	) else $error("serial write lost in power-down");

	chk_pending_clear: assert property (
		start |=> !pending_q ##1 eng_busy
	) else $error("pending load not cleared after start");

	// the update lands on the edge that drops our own drive, so no change is seen under it
	chk_code_on_update: assert property (
		$changed(dac_code_o) |-> dac_update_o || $past(any_reset)
	) else $error("converter register changed without an update");

	chk_release_first: assert property (
		dac_update_o |-> !busy_n_oe_o
	) else $error("converter updated while busy still driven");

	chk_strobe_start: assert property (
		load_fall && busy_n_i && !int_busy |=> busy_n_oe_o && eng_busy
	) else $error("load strobe on a free line did not start");

	chk_pending_run: assert property (
		pending_q && busy_n_i && !int_busy |=> busy_n_oe_o && !pending_q
	) else $error("stored load not run when busy released");

	chk_ready_quiet: assert property (
		ready_n_o && !frame_done_i |=> ready_n_o
	) else $error("ready asserted without a finished frame");

	chk_ready_hold: assert property (
		!ready_n_o && !cs_rise |=> !ready_n_o
	) else $error("ready released before chip select rise");

	chk_sw_busy: assert property (
		sw_reset_i && !in_reset |=> sw_window
	) else $error("busy not held through the software reset window");

endmodule

// *** tb/busy_wire_host.sv ***
// host side of the open-drain busy wire: pull-up plus an optional external hold low
// assumes the device drives the wire only while its output enable is high
module busy_wire_host (
	// device drive
	input  wire logic busy_n_oe_i,
	input  wire logic drive_i,
	// host control
	input  wire logic hold_low_i,
	// resolved wire
	output logic      busy_line_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// released wire floats to the pull-up level, never to the last driven value
	assign busy_line_o = !((busy_n_oe_i && !drive_i) || hold_low_i);
endmodule

// *** tb/dac_load_busy_reset_control_test.sv ***
// self-checking bench for the converter load, busy and reset control
// assumes the package and design files are compiled first
module dac_load_busy_reset_control_test;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic        fmt;
		logic [17:0] data;
		logic [17:0] gain;
		logic [17:0] off;
		logic [17:0] exp;
	} row_t;

	logic clk = 0, rst = 1, hw_n = 1, sw = 0, rsel = 1, fmt = 0, pd = 0;
	logic cs_n = 1, fdone = 0, ld_n = 1, hold = 0;
	logic busy_line, bo, oe, rdy_n, upd, pdo, moved;
	logic [17:0] code;
	dac_ctrl_pkg::frame_write_t fw = '0;
	int mismatches = 0;
	int check_count = 0;
	int n, hi;
	row_t rows[6] = '{
		'{1'b0, 18'h2_0000, 18'h3_FFFF, 18'h0_0000, 18'h1_FFFF},
		'{1'b1, 18'h0_0000, 18'h2_0000, 18'h0_0000, 18'h1_0000},
		'{1'b0, 18'h3_FFFF, 18'h3_FFFF, 18'h0_0010, 18'h3_FFFF},
		'{1'b0, 18'h0_0100, 18'h3_FFFF, 18'h3_FFF0, 18'h0_00EF},
		'{1'b0, 18'h0_0004, 18'h3_FFFF, 18'h3_FFF0, 18'h0_0000},
		'{1'b1, 18'h3_FFFF, 18'h2_0000, 18'h0_0000, 18'h0_FFFF}};

	always #25 clk = !clk;

	dac_load_busy_reset_control uut (
		.sys_clk_i(clk), .reset_i(rst), .hw_reset_n_i(hw_n), .sw_reset_i(sw),
		.reset_level_select_i(rsel), .input_format_select_i(fmt),
		.power_down_in_i(pd), .cs_n_i(cs_n), .frame_write_i(fw),
		.frame_done_i(fdone), .load_strobe_n_i(ld_n), .busy_n_i(busy_line),
		.busy_n_o(bo), .busy_n_oe_o(oe), .ready_n_o(rdy_n), .dac_code_o(code),
		.dac_update_o(upd), .power_down_o(pdo));

	busy_wire_host host (.busy_n_oe_i(oe), .drive_i(bo), .hold_low_i(hold),
		.busy_line_o(busy_line));

	task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		if (mismatches == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [1:0] t, input logic [17:0] v);
		@(posedge clk);
		fw <= '{1'b1, dac_ctrl_pkg::wr_target_t'(t), v};
		@(posedge clk);
		fw <= '0;
	endtask

	// strobe low for one cycle; returns at the edge that sees it low
	task automatic load();
		@(posedge clk);
		ld_n <= 1'b0;
		@(posedge clk);
		ld_n <= 1'b1;
	endtask

	// n ends at lim when no update came; hi counts cycles with the wire released
	task automatic wait_upd(input int lim);
		logic [17:0] c0;
		c0 = code;
		n = 0;
		hi = 0;
		moved = 0;
		do begin
			step();
			n++;
			if (upd !== 1'b1) begin
				hi += (busy_line !== 1'b0);
				moved |= (code !== c0);
			end
		end while (n < lim && upd !== 1'b1);
	endtask

	initial begin
		repeat (4000) @(posedge clk);
		mismatches++;
		stop_test();
	end

	initial begin
		repeat (16) @(posedge clk);
		#1;
		chk("reset oe", 18'h0_0001, 18'(oe));
		chk("reset code", 18'h2_0000, code);
		@(posedge clk);
		rst <= 1'b0;
		repeat (2) step();
		chk("idle line", 18'h0_0001, 18'(busy_line));
		chk("idle ready", 18'h0_0001, 18'(rdy_n));
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			fmt <= rows[i].fmt;
			wr(2, rows[i].gain);
			wr(1, rows[i].off);
			wr(0, rows[i].data);
			load();
			wait_upd(40);
			chk("latency", 18'h0_0014, 18'(n));
			chk("busy line", 18'h0_0000, 18'(hi));
			chk("held code", 18'h0_0000, 18'(moved));
			chk("code", rows[i].exp, code);
		end
		// second strobe and a data write land while the first calculation runs
		@(posedge clk);
		fmt <= 1'b0;
		wr(0, 18'h0_0100);
		load();
		wr(0, 18'h0_0200);
		load();
		wait_upd(40);
		chk("first", 18'h0_0080, code);
		wait_upd(40);
		chk("deferred", 18'h0_0100, code);
		wait_upd(40);
		chk("extra", 18'h0_0028, 18'(n));
		@(posedge clk);
		hold <= 1'b1;
		wr(0, 18'h0_0300);
		load();
		wait_upd(10);
		chk("held off", 18'h0_000A, 18'(n));
		@(posedge clk);
		hold <= 1'b0;
		wait_upd(40);
		chk("released", 18'h0_0180, code);
		@(posedge clk);
		cs_n <= 1'b0;
		fdone <= 1'b1;
		@(posedge clk);
		fdone <= 1'b0;
		repeat (4) step();
		chk("ready low", 18'h0_0000, 18'(rdy_n));
		@(posedge clk);
		cs_n <= 1'b1;
		repeat (3) step();
		chk("ready high", 18'h0_0001, 18'(rdy_n));
		@(posedge clk);
		rsel <= 1'b0;
		hw_n <= 1'b0;
		load();
		wait_upd(6);
		chk("hw ignore", 18'h0_0006, 18'(n));
		chk("hw line", 18'h0_0000, 18'(busy_line));
		chk("hw code", 18'h0_0000, code);
		@(posedge clk);
		hw_n <= 1'b1;
		wait_upd(10);
		chk("hw keep", 18'h0_000A, 18'(n));
		chk("hw held", 18'h0_0000, 18'(moved));
		load();
		wait_upd(40);
		chk("reset load", 18'h0_0014, 18'(n));
		chk("defaults", 18'h0_0000, code);
		// pending strobe must not survive a software reset
		@(posedge clk);
		hold <= 1'b1;
		load();
		@(posedge clk);
		sw <= 1'b1;
		@(posedge clk);
		sw <= 1'b0;
		step();
		chk("sw oe", 18'h0_0001, 18'(oe));
		@(posedge clk);
		hold <= 1'b0;
		wait_upd(30);
		chk("sw pending", 18'h0_001E, 18'(n));
		@(posedge clk);
		pd <= 1'b1;
		wr(0, 18'h0_0400);
		wr(2, 18'h2_0000);
		// a write to no register must leave the data word alone
		wr(3, 18'h3_FFFF);
		load();
		wait_upd(40);
		chk("pd mirror", 18'h0_0001, 18'(pdo));
		chk("pd code", 18'h0_0200, code);
		stop_test();
	end
endmodule
